// ===== common/lc_scan_pkg.sv
// Shared constants and types for the LC sensor scan sequencer
package lc_scan_pkg;

    // ========================================================
    // Clock and timing
    localparam int unsigned CLK_MHZ         = 40;
    localparam int unsigned CLK_HZ          = CLK_MHZ * 1000000;
    localparam int unsigned PULSE_TIME_NS   = 30000;
    localparam int unsigned PULSE_CYCLES    = (PULSE_TIME_NS * CLK_MHZ) / 1000;
    localparam int unsigned SAMPLE_RATE_HZ  = 320;
    localparam int unsigned MOD_W           = 24;
    localparam int unsigned RAM_DEPTH       = 64;
    localparam int unsigned PTR_W           = 6;
    localparam int unsigned CNT_W           = 16;

    // ========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL        = 8'h00;
    localparam logic [7:0] OFS_STATUS      = 8'h04;
    localparam logic [7:0] OFS_MODULO      = 8'h08;
    localparam logic [7:0] OFS_ARM_DAC     = 8'h0C;
    localparam logic [7:0] OFS_ARM_MUX     = 8'h10;
    localparam logic [7:0] OFS_DISARM      = 8'h14;
    localparam logic [7:0] OFS_PTR         = 8'h18;
    localparam logic [7:0] OFS_COUNT       = 8'h1C;
    localparam logic [7:0] OFS_RAM_ADDR    = 8'h20;
    localparam logic [7:0] OFS_RAM_DATA    = 8'h24;

    // ========================================================
    // Field positions
    localparam int unsigned CTRL_RUN_BIT   = 0;
    localparam int unsigned CTRL_WCLR_BIT  = 1;
    localparam int unsigned ST_WAKE_BIT    = 0;
    localparam int unsigned ST_SEL_BIT     = 1;
    localparam int unsigned ST_CMPON_BIT   = 2;

    // ========================================================
    // Reset values
    localparam logic [7:0] RST_ARM_DAC     = 8'hA0;
    localparam logic [7:0] RST_ARM_MUX0    = 8'h0F;
    localparam logic [7:0] RST_ARM_MUX1    = 8'h1F;
    localparam logic [7:0] RST_DIS_DAC     = 8'h00;
    localparam logic [7:0] RST_DIS_MUX     = 8'h00;
    localparam logic [CNT_W-1:0] RST_COUNT = 16'h0010;

    // ========================================================
    // Carriers
    typedef struct packed {
        logic       en;
        logic       spare;
        logic [5:0] level;
    } dac_ctrl_type;

    typedef struct packed {
        logic [1:0] spare;
        logic [2:0] plus_sel;
        logic [2:0] minus_sel;
    } comp_mux_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARM_DAC,
        ST_ARM_MUX,
        ST_CAPTURE,
        ST_DIS_DAC,
        ST_DIS_MUX
    } xfer_state_type;

endpackage : lc_scan_pkg

// ===== core/lc_sensor_scan_sequencer.sv
// Timer driven two-sensor LC scan sequencer with capture RAM
//
// Notes on behaviour
// - Each channel moves one burst per trigger: two bytes to arm or disarm, one to capture
// - Scanning runs in sleep without processor
// - Both timers count the one bus clock
// - Modulo value sets the sampling period
// - Sample timer triggers channels, drives excitation
// - Select timer enables only scanned sensor
// - Arm, capture, disarm repeat every period
// - Compare event arms: DAC byte, then mux
// - DAC byte holds enable and level
// - Arm mux joins sensor input to DAC
// - Comparator off while mux pairing invalid
// - Excitation state drives the output pin
// - Overflow captures comparator status to RAM while count is nonzero
// - One RAM byte array, samples in order
// - Disarm starts when capture completes
// - Disarm turns DAC off, comparator off
// - Wake processor after preset cycle count
// - Excitation pulse about 30 us per period
// - Sensor enables are always inverse, alternating
// - Sample comparator at end of pulse
`timescale 1ns/1ps
`default_nettype none

module lc_sensor_scan_sequencer #(
    parameter int unsigned SAMPLE_MODULO =
        lc_scan_pkg::CLK_HZ / lc_scan_pkg::SAMPLE_RATE_HZ
) (
    input  wire logic                      clk_sys,
    input  wire logic                      resetn,
    input  wire logic [7:0]                reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic [31:0]                    reg_rdata,
    input  wire logic                      cmp_result,
    output lc_scan_pkg::dac_ctrl_type      threshold_dac,
    output lc_scan_pkg::comp_mux_type      comparator_input_select,
    output logic                           comparator_on,
    output logic                           excitation_output,
    output logic                           sensor0_enable_out,
    output logic                           sensor1_enable_out,
    output logic                           wake_request
);

    // ========================================================
    // Decoding used by logic; mux_valid also shared with checks
    function automatic logic mux_valid(input lc_scan_pkg::comp_mux_type m);
        mux_valid = (m.plus_sel != m.minus_sel);
    endfunction : mux_valid

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    // ========================================================
    // Registers
    logic                            run_r, run_nxt;
    logic [lc_scan_pkg::MOD_W-1:0]   modulo_r, modulo_nxt;
    logic [7:0]                      arm_dac_r, arm_dac_nxt;
    logic [15:0]                     arm_mux_r, arm_mux_nxt;
    logic [15:0]                     disarm_r, disarm_nxt;
    logic [lc_scan_pkg::PTR_W-1:0]   ptr_r, ptr_nxt;
    logic [lc_scan_pkg::CNT_W-1:0]   count_r, count_nxt;
    logic [lc_scan_pkg::PTR_W-1:0]   rd_ptr_r, rd_ptr_nxt;
    logic                            wake_r, wake_nxt;
    logic [lc_scan_pkg::MOD_W-1:0]   tmr_r, tmr_nxt;
    logic                            exc_r, exc_nxt;
    logic                            sel_r, sel_nxt;
    lc_scan_pkg::xfer_state_type     state_r, state_nxt;
    logic                            arm_pend_r, arm_pend_nxt;
    logic                            cap_pend_r, cap_pend_nxt;
    lc_scan_pkg::dac_ctrl_type       dac_r, dac_nxt;
    lc_scan_pkg::comp_mux_type       mux_r, mux_nxt;
    logic [31:0]                     rdata_r, rdata_nxt;
    logic [7:0]                      ram [lc_scan_pkg::RAM_DEPTH];

    logic [lc_scan_pkg::MOD_W-1:0]   cmp_point;
    logic                            arm_ev;
    logic                            ovf_ev;
    logic                            cap_write;
    logic [7:0]                      status_byte;

    // ========================================================
    // Sample timer and sensor select timer
    // Modulo below the pulse length gives a pulse-free period.
    // One cycle early, so the pulse spans the full count
    assign cmp_point = modulo_r -
        lc_scan_pkg::MOD_W'(lc_scan_pkg::PULSE_CYCLES + 1);
    // Timers see only the bus clock, run flag and modulo, never the CPU
    assign arm_ev = run_r && (tmr_r == cmp_point);
    assign ovf_ev = run_r && (tmr_r == modulo_r - 1'b1);

    always_comb
    begin
        tmr_nxt = tmr_r;
        exc_nxt = 1'b0;
        sel_nxt = sel_r;
        if (run_r)
        begin
            tmr_nxt = ovf_ev ? '0 : tmr_r + 1'b1;
            // High from compare point until overflow: 30 us
            exc_nxt = (tmr_r >= cmp_point) && !ovf_ev;
            // Swap after capture, so the byte names the scanned sensor
            if (state_r == lc_scan_pkg::ST_CAPTURE)
                sel_nxt = ~sel_r;
        end
        else
        begin
            tmr_nxt = '0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            tmr_r <= '0;
            exc_r <= 1'b0;
            sel_r <= 1'b0;
        end
        else
        begin
            tmr_r <= tmr_nxt;
            exc_r <= exc_nxt;
            sel_r <= sel_nxt;
        end
    end

    assign excitation_output  = exc_r;
    assign sensor0_enable_out = ~sel_r;
    assign sensor1_enable_out = sel_r;

    // ========================================================
    // Transfer channels: one byte per step, one burst per trigger
    assign status_byte = {5'h00, sel_r, comparator_on, cmp_result};
    assign cap_write   = (state_r == lc_scan_pkg::ST_CAPTURE) &&
                         (count_r != '0);

    always_comb
    begin
        state_nxt    = state_r;
        arm_pend_nxt = arm_pend_r | arm_ev;
        cap_pend_nxt = cap_pend_r | ovf_ev;
        dac_nxt      = dac_r;
        mux_nxt      = mux_r;
        ptr_nxt      = ptr_r;
        count_nxt    = count_r;
        case (state_r)
            lc_scan_pkg::ST_IDLE:
            begin
                // Capture outranks arm; triggers never collide in use
                if (ovf_ev || cap_pend_r)
                begin
                    state_nxt    = lc_scan_pkg::ST_CAPTURE;
                    cap_pend_nxt = 1'b0;
                end
                else if (arm_ev || arm_pend_r)
                begin
                    state_nxt    = lc_scan_pkg::ST_ARM_DAC;
                    arm_pend_nxt = 1'b0;
                end
            end
            lc_scan_pkg::ST_ARM_DAC:
            begin
                dac_nxt   = arm_dac_r;
                state_nxt = lc_scan_pkg::ST_ARM_MUX;
            end
            lc_scan_pkg::ST_ARM_MUX:
            begin
                mux_nxt   = sel_r ? arm_mux_r[15:8]
                                  : arm_mux_r[7:0];
                state_nxt = lc_scan_pkg::ST_IDLE;
            end
            lc_scan_pkg::ST_CAPTURE:
            begin
                if (cap_write)
                begin
                    ptr_nxt   = ptr_r + 1'b1;
                    count_nxt = count_r - 1'b1;
                end
                state_nxt = lc_scan_pkg::ST_DIS_DAC;
            end
            lc_scan_pkg::ST_DIS_DAC:
            begin
                dac_nxt   = disarm_r[7:0];
                state_nxt = lc_scan_pkg::ST_DIS_MUX;
            end
            lc_scan_pkg::ST_DIS_MUX:
            begin
                mux_nxt   = disarm_r[15:8];
                state_nxt = lc_scan_pkg::ST_IDLE;
            end
            default:
            begin
                state_nxt = lc_scan_pkg::ST_IDLE;
            end
        endcase
        if (!run_r)
        begin
            arm_pend_nxt = 1'b0;
            cap_pend_nxt = 1'b0;
        end
        // Software reload of pointer and count takes effect at once
        if (reg_wr && hit(reg_addr, lc_scan_pkg::OFS_PTR))
            ptr_nxt = reg_wdata[lc_scan_pkg::PTR_W-1:0];
        if (reg_wr && hit(reg_addr, lc_scan_pkg::OFS_COUNT))
            count_nxt = reg_wdata[lc_scan_pkg::CNT_W-1:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            state_r    <= lc_scan_pkg::ST_IDLE;
            arm_pend_r <= 1'b0;
            cap_pend_r <= 1'b0;
            dac_r      <= '0;
            mux_r      <= '0;
            ptr_r      <= '0;
            count_r    <= lc_scan_pkg::RST_COUNT;
        end
        else
        begin
            state_r    <= state_nxt;
            arm_pend_r <= arm_pend_nxt;
            cap_pend_r <= cap_pend_nxt;
            dac_r      <= dac_nxt;
            mux_r      <= mux_nxt;
            ptr_r      <= ptr_nxt;
            count_r    <= count_nxt;
        end
    end

    // Comparator read right after pulse end, sensor chosen by mux
    always_ff @(posedge clk_sys)
    begin
        if (cap_write)
            ram[ptr_r] <= status_byte;
    end

    assign threshold_dac           = dac_r;
    assign comparator_input_select = mux_r;
    assign comparator_on           = mux_valid(mux_r);
    assign wake_request            = wake_r;

    // ========================================================
    // Register bus slave
    always_comb
    begin
        run_nxt    = run_r;
        modulo_nxt = modulo_r;
        arm_dac_nxt = arm_dac_r;
        arm_mux_nxt = arm_mux_r;
        disarm_nxt = disarm_r;
        rd_ptr_nxt = rd_ptr_r;
        wake_nxt   = wake_r;
        rdata_nxt  = 32'h0000_0000;
        if (reg_wr)
        begin
            if (hit(reg_addr, lc_scan_pkg::OFS_CTRL))
            begin
                run_nxt = reg_wdata[lc_scan_pkg::CTRL_RUN_BIT];
                if (reg_wdata[lc_scan_pkg::CTRL_WCLR_BIT])
                    wake_nxt = 1'b0;
            end
            if (hit(reg_addr, lc_scan_pkg::OFS_MODULO))
                modulo_nxt = reg_wdata[lc_scan_pkg::MOD_W-1:0];
            if (hit(reg_addr, lc_scan_pkg::OFS_ARM_DAC))
                arm_dac_nxt = reg_wdata[7:0];
            if (hit(reg_addr, lc_scan_pkg::OFS_ARM_MUX))
                arm_mux_nxt = reg_wdata[15:0];
            if (hit(reg_addr, lc_scan_pkg::OFS_DISARM))
                disarm_nxt = reg_wdata[15:0];
            if (hit(reg_addr, lc_scan_pkg::OFS_RAM_ADDR))
                rd_ptr_nxt = reg_wdata[lc_scan_pkg::PTR_W-1:0];
        end
        // Set wins over a clear in the same cycle
        if (cap_write && (count_r == lc_scan_pkg::CNT_W'(1)))
            wake_nxt = 1'b1;
        if (reg_rd)
        begin
            case (reg_addr)
                lc_scan_pkg::OFS_CTRL:     rdata_nxt = {31'h0, run_r};
                lc_scan_pkg::OFS_STATUS:   rdata_nxt = {29'h0,
                    comparator_on, sel_r, wake_r};
                lc_scan_pkg::OFS_MODULO:   rdata_nxt = {8'h00, modulo_r};
                lc_scan_pkg::OFS_ARM_DAC:  rdata_nxt = {24'h0, arm_dac_r};
                lc_scan_pkg::OFS_ARM_MUX:  rdata_nxt = {16'h0, arm_mux_r};
                lc_scan_pkg::OFS_DISARM:   rdata_nxt = {16'h0, disarm_r};
                lc_scan_pkg::OFS_PTR:      rdata_nxt = {26'h0, ptr_r};
                lc_scan_pkg::OFS_COUNT:    rdata_nxt = {16'h0, count_r};
                lc_scan_pkg::OFS_RAM_ADDR: rdata_nxt = {26'h0, rd_ptr_r};
                lc_scan_pkg::OFS_RAM_DATA: rdata_nxt = {24'h0, ram[rd_ptr_r]};
                default:                   rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            run_r     <= 1'b0;
            modulo_r  <= lc_scan_pkg::MOD_W'(SAMPLE_MODULO);
            arm_dac_r <= lc_scan_pkg::RST_ARM_DAC;
            arm_mux_r <= {lc_scan_pkg::RST_ARM_MUX1,
                          lc_scan_pkg::RST_ARM_MUX0};
            disarm_r  <= {lc_scan_pkg::RST_DIS_MUX, lc_scan_pkg::RST_DIS_DAC};
            rd_ptr_r  <= '0;
            wake_r    <= 1'b0;
            rdata_r   <= 32'h0000_0000;
        end
        else
        begin
            run_r     <= run_nxt;
            modulo_r  <= modulo_nxt;
            arm_dac_r <= arm_dac_nxt;
            arm_mux_r <= arm_mux_nxt;
            disarm_r  <= disarm_nxt;
            rd_ptr_r  <= rd_ptr_nxt;
            wake_r    <= wake_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // ========================================================
    // Checks
    logic [15:0] hi_len_r;

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            hi_len_r <= '0;
        else
            hi_len_r <= exc_r ? hi_len_r + 1'b1 : 16'h0000;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_arm_order: assert property (
        $rose(exc_r) |-> state_r == lc_scan_pkg::ST_ARM_DAC
            ##1 state_r == lc_scan_pkg::ST_ARM_MUX)
        else $error("arm sequence out of order");
    a_arm_mux_sel: assert property (
        state_r == lc_scan_pkg::ST_ARM_MUX |=>
            mux_r == (sel_r ? arm_mux_r[15:8] : arm_mux_r[7:0]))
        else $error("arm mux not for scanned sensor");
    a_capture_trig: assert property (
        ovf_ev && state_r == lc_scan_pkg::ST_IDLE |=>
            state_r == lc_scan_pkg::ST_CAPTURE)
        else $error("overflow did not capture");
    a_disarm_link: assert property (
        state_r == lc_scan_pkg::ST_CAPTURE |=>
            state_r == lc_scan_pkg::ST_DIS_DAC
            ##1 state_r == lc_scan_pkg::ST_DIS_MUX
            ##1 state_r == lc_scan_pkg::ST_IDLE)
        else $error("disarm not linked to capture");
    a_disarm_off: assert property (
        state_r == lc_scan_pkg::ST_DIS_MUX && !mux_valid(disarm_r[15:8])
            |=> !comparator_on)
        else $error("comparator left on after disarm");
    a_enable_inv: assert property (
        sensor0_enable_out != sensor1_enable_out)
        else $error("sensor enables not inverse");
    a_enable_alt: assert property (
        state_r == lc_scan_pkg::ST_CAPTURE |=>
            $changed(sensor1_enable_out))
        else $error("sensor enables not alternating");
    // A software stop may cut a pulse short
    a_pulse_width: assert property (
        $fell(exc_r) && run_r |->
            hi_len_r == 16'(lc_scan_pkg::PULSE_CYCLES))
        else $error("excitation pulse length wrong");
    a_ptr_step: assert property (
        cap_write && !reg_wr |=> ptr_r == $past(ptr_r) + 1'b1)
        else $error("pointer did not advance");
    a_wake_count: assert property (
        cap_write && count_r == 1 && !reg_wr |=> wake_r && count_r == 0)
        else $error("wake not raised at count zero");

endmodule : lc_sensor_scan_sequencer

`default_nettype wire

// ===== test/lc_sensor_front_model.sv
// Behavioural envelope detectors and comparator of the two sensors
`timescale 1ns/1ps
`default_nettype none

module lc_sensor_front_model #(
    parameter logic NEAR0 = 1'b1,
    parameter logic NEAR1 = 1'b0
) (
    input  wire logic clk_sys,
    input  wire logic sensor0_enable,
    input  wire logic sensor1_enable,
    input  wire logic comparator_on,
    output logic      cmp_result
);

    // ========================================================
    // Comparator output
    // Dead comparator wanders, so a capture of it cannot pass by luck
    logic idle_r = 1'b0;

    always @(posedge clk_sys)
        idle_r <= ~idle_r;

    assign cmp_result = !comparator_on ? idle_r :
                        (sensor1_enable && !sensor0_enable) ? NEAR1 : NEAR0;

endmodule : lc_sensor_front_model
`default_nettype wire

// ===== test/lc_sensor_scan_sequencer_tb.sv
// Self-checking bench of the LC sensor scan sequencer
`timescale 1ns/1ps
`default_nettype none

module lc_sensor_scan_sequencer_tb;

    // ========================================================
    // Signals
    localparam int unsigned MODULO = 1300;
    localparam int unsigned LIMIT  = 20000;

    logic                      clk_sys;
    logic                      resetn;
    logic [7:0]                reg_addr;
    logic [31:0]               reg_wdata;
    logic                      reg_wr;
    logic                      reg_rd;
    logic [31:0]               reg_rdata;
    logic                      cmp_result;
    lc_scan_pkg::dac_ctrl_type threshold_dac;
    lc_scan_pkg::comp_mux_type comparator_input_select;
    logic                      comparator_on;
    logic                      excitation_output;
    logic                      sensor0_enable_out;
    logic                      sensor1_enable_out;
    logic                      wake_request;
    int                        fails;
    int                        n_compared;
    int                        cycles;
    int                        rise_at;
    logic [31:0]               rd;

    lc_sensor_scan_sequencer #(
        .SAMPLE_MODULO(MODULO)
    ) i_lc_sensor_scan_sequencer (
        .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cmp_result(cmp_result),
        .threshold_dac(threshold_dac),
        .comparator_input_select(comparator_input_select),
        .comparator_on(comparator_on), .excitation_output(excitation_output),
        .sensor0_enable_out(sensor0_enable_out),
        .sensor1_enable_out(sensor1_enable_out), .wake_request(wake_request)
    );

    lc_sensor_front_model i_lc_sensor_front_model (
        .clk_sys(clk_sys), .sensor0_enable(sensor0_enable_out),
        .sensor1_enable(sensor1_enable_out), .comparator_on(comparator_on),
        .cmp_result(cmp_result)
    );

    // ========================================================
    // Clock, timeout, tasks
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            fails++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (fails == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask : reg_read

    // Enables stay complementary every cycle
    always @(negedge clk_sys)
        if (resetn)
            check(32'(sensor0_enable_out ^ sensor1_enable_out), 32'h1);

    // One sampling period: arm, pulse, capture, disarm
    task automatic check_period(input logic sel, input logic first);
        int n;
        n = 0;
        while (excitation_output !== 1'b1 && n < 2 * MODULO)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (!first)
            check(32'(cycles - rise_at), MODULO);
        rise_at = cycles;
        check(32'({sensor0_enable_out, sel}), 32'({~sel, sel}));
        repeat (3) @(negedge clk_sys);
        check({threshold_dac, comparator_input_select, comparator_on},
              {8'hBF, sel ? 8'h1A : 8'h0A, 1'b1});
        n = 4;
        while (excitation_output === 1'b1 && n < 2 * MODULO)
        begin
            @(negedge clk_sys);
            if (excitation_output === 1'b1)
                n++;
        end
        check(32'(n), lc_scan_pkg::PULSE_CYCLES);
        repeat (4) @(negedge clk_sys);
        check({threshold_dac, comparator_input_select, comparator_on,
               sensor0_enable_out},
              {8'h05, 8'h2D, 1'b0, sel});
    endtask : check_period

    // ========================================================
    // Main sequence
    initial
    begin
        resetn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        fails = 0;
        n_compared = 0;
        cycles = 0;
        rise_at = 0;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        @(negedge clk_sys);
        check({threshold_dac, comparator_input_select, comparator_on,
               excitation_output, sensor0_enable_out, wake_request},
              {8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0});
        reg_read(lc_scan_pkg::OFS_ARM_DAC, rd);
        check(rd, 32'h0000_00A0);
        reg_read(lc_scan_pkg::OFS_ARM_MUX, rd);
        check(rd, 32'h0000_1F0F);
        reg_read(lc_scan_pkg::OFS_DISARM, rd);
        check(rd, 32'h0000_0000);
        reg_read(lc_scan_pkg::OFS_COUNT, rd);
        check(rd, 32'h0000_0010);
        reg_read(8'h30, rd);
        check(rd, 32'h0000_0000);
        // Rate well above twice the need of both sensors
        reg_write(lc_scan_pkg::OFS_MODULO, MODULO);
        reg_write(lc_scan_pkg::OFS_ARM_DAC, 32'h0000_00BF);
        reg_write(lc_scan_pkg::OFS_ARM_MUX, 32'h0000_1A0A);
        reg_write(lc_scan_pkg::OFS_DISARM, 32'h0000_2D05);
        reg_write(lc_scan_pkg::OFS_COUNT, 32'h0000_0003);
        reg_write(lc_scan_pkg::OFS_PTR, 32'h0000_0000);
        reg_write(lc_scan_pkg::OFS_CTRL, 32'h0000_0001);
        // No bus traffic while scanning
        for (int i = 0; i < 4; i++)
        begin
            check_period(i[0], i == 0);
            check(32'(wake_request), 32'(i >= 2));
        end
        reg_read(lc_scan_pkg::OFS_PTR, rd);
        check(rd, 32'h0000_0003);
        reg_read(lc_scan_pkg::OFS_COUNT, rd);
        check(rd, 32'h0000_0000);
        for (int k = 0; k < 3; k++)
        begin
            reg_write(lc_scan_pkg::OFS_RAM_ADDR, 32'(k));
            reg_read(lc_scan_pkg::OFS_RAM_DATA, rd);
            check(rd, k[0] ? 32'h0000_0006 : 32'h0000_0003);
        end
        reg_write(lc_scan_pkg::OFS_CTRL, 32'h0000_0003);
        reg_read(lc_scan_pkg::OFS_STATUS, rd);
        check({rd[0], wake_request}, 2'b00);
        reg_write(lc_scan_pkg::OFS_CTRL, 32'h0000_0000);
        // Stop lands early in the period, before the pulse; no pulse follows for two periods
        @(posedge clk_sys);
        rise_at = 0;
        repeat (2 * MODULO)
        begin
            @(negedge clk_sys);
            if (excitation_output !== 1'b0)
                rise_at++;
        end
        check(32'(rise_at), 32'h0);
        print_verdict();
    end

endmodule : lc_sensor_scan_sequencer_tb
`default_nettype wire
